// [common/chip_ctl_defines.svh]
/*
 Offsets, field positions, reset values and timing figures of the bridge
 chip control register, upper half (bits 31:15) at configuration offset 40h.
 Assumes a 200 MHz core clock; times are given in ns and turned into
 cycles by the modules that use them.
*/
//Contract
//- Credit updates go out per two freed credits when bit 15 is 0, else each.
//- Bit 16 sets on retry counter expiry and clears only by writing one.
//- Bits 18:17 pick the retry limit: none, 256, 64K or 2G.
//- Bit 19 disables the PCI discard timer together with bridge control bit 27.
//- Bit 20 gives 64 clock discard expiry, else bit 24 or 25 of 3Ch.
//- Bits 22:21 pick config retry timeout 25us, 0.5ms, 5ms or 25ms.
//- Bit 23 set forces delayed transactions to complete strictly in order.
//- Bits 25:24 pick completion timeout 50us, 10ms, 50ms or disabled.
//- Bit 26 clear maps PCI-to-PCIe memory traffic to TC0, else to bits 29:27.
//- Bits 29:27 hold the isochronous traffic class, resetting to 001.
//- Bit 30 gates core clocks while the link sits in L1 or L1s.
//- Bit 31 locks out primary configuration access with CRS or target retry.
`ifndef CHIP_CTL_DEFINES_SVH
`define CHIP_CTL_DEFINES_SVH

`define CTL_OFFSET      8'h40
`define CTL_RESET       32'h0920_0000
`define CTL_RW_MASK     32'hfffe_8000
`define FC_BIT          15
`define RETRY_STS_BIT   16
`define RETRY_SEL_LO    17
`define RETRY_SEL_HI    18
`define DISC_DIS_BIT    19
`define DISC_SHORT_BIT  20
`define CRS_SEL_LO      21
`define CRS_SEL_HI      22
`define DT_ORDER_BIT    23
`define CPL_SEL_LO      24
`define CPL_SEL_HI      25
`define ISO_EN_BIT      26
`define TC_LO           27
`define TC_HI           29
`define PWR_SAVE_BIT    30
`define LOCKOUT_BIT     31

`define TC_ZERO         3'h0
`define RETRY_LIM_256   32'h0000_0100
`define RETRY_LIM_64K   32'h0001_0000
`define RETRY_LIM_2G    32'h8000_0000

`define DISC_SHORT_CLK  16'h0040
`define DISC_BC_SHORT   16'h0400
`define DISC_BC_LONG    16'h8000

`define CLK_PERIOD_NS   5
`define CRS_T0_NS       25000
`define CRS_T1_NS       500000
`define CRS_T2_NS       5000000
`define CRS_T3_NS       25000000
`define CPL_T0_NS       50000
`define CPL_T1_NS       10000000
`define CPL_T2_NS       50000000

`endif

// [common/chip_ctl_pkg.sv]
/*
 Types shared by the control register bank and its retry counter.
 Assumes chip_ctl_defines.svh is on the include path.
*/
`default_nettype none
package chip_ctl_pkg;
  typedef logic [1:0]  sel_t;
  typedef logic [23:0] tcount_t;

  typedef struct packed {
    logic [31:0] ctl;
    logic        fc_half;
    logic        fc_update;
    logic        crs_run;
    tcount_t     crs_cnt;
    logic        crs_timeout;
    logic        cpl_run;
    tcount_t     cpl_cnt;
    logic        cpl_timeout;
    logic        cfg_ack;
    logic        cfg_crs;
    logic        cfg_tretry;
    logic [31:0] cfg_rdata;
    logic        disc_en;
    logic [15:0] disc_limit;
    logic [2:0]  tc;
    logic        dt_in_order;
    logic        clk_gate;
  } ctl_state_t;

  typedef struct packed {
    logic [31:0] count;
    logic        done;
    logic        expired;
  } retry_state_t;
endpackage
`default_nettype wire

// [common/retry_if.sv]
/*
 Carrier between the register bank and the PCI retry counter.
 Assumes both ends sit on the same clock.
*/
`default_nettype none
interface retry_if;
  logic [1:0] limit_sel;
  logic       txn_new;
  logic       retry;
  logic       expired;
  modport ctl (output limit_sel, output txn_new, output retry,
               input expired);
  modport cnt (input limit_sel, input txn_new, input retry,
               output expired);
endinterface
`default_nettype wire

// [src/pci_retry_counter.sv]
/*
 Counts target retries for the pending PCI transaction and pulses expired
 once the selected limit is reached. Assumes one clock and the txn_new
 pulse at the start of each transaction.
*/
`default_nettype none
`include "chip_ctl_defines.svh"
module pci_retry_counter (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Counter side of the carrier
  retry_if.cnt      rif
);
  import chip_ctl_pkg::*;

  retry_state_t st_r;
  retry_state_t st_nxt;

  function automatic logic [31:0] limit_of(input sel_t sel);
    unique case (sel)
      2'b00: limit_of = '0;
      2'b01: limit_of = `RETRY_LIM_256;
      2'b10: limit_of = `RETRY_LIM_64K;
      2'b11: limit_of = `RETRY_LIM_2G;
    endcase
  endfunction

  always_comb begin
    st_nxt         = st_r;
    st_nxt.expired = 1'b0;
    if (rif.txn_new) begin
      st_nxt.count = '0;
      st_nxt.done  = 1'b0;
    end else if (rif.retry && !st_r.done) begin
      st_nxt.count = st_r.count + 32'h1;
      // A zero limit would match any stepped count, so it is ruled out
      if (limit_of(rif.limit_sel) != '0 &&
          st_nxt.count >= limit_of(rif.limit_sel)) begin
        st_nxt.expired = 1'b1;
        st_nxt.done    = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rif.expired = st_r.expired;
endmodule
`default_nettype wire

// [src/chip_ctl_upper.sv]
/*
 Bridge chip control register, bits 31:15 at configuration offset 40h,
 with the logic those bits steer: credit update pacing, retry expiry
 status, discard timer setup, the configuration retry and completion
 timers, traffic class mapping, L1 clock gating and primary lockout.
 Assumes one configuration access per strobe and synchronous inputs.
*/
`default_nettype none
`include "chip_ctl_defines.svh"
module chip_ctl_upper #(
  parameter int CRS_CYC0 = `CRS_T0_NS / `CLK_PERIOD_NS,
  parameter int CRS_CYC1 = `CRS_T1_NS / `CLK_PERIOD_NS,
  parameter int CRS_CYC2 = `CRS_T2_NS / `CLK_PERIOD_NS,
  parameter int CRS_CYC3 = `CRS_T3_NS / `CLK_PERIOD_NS,
  parameter int CPL_CYC0 = `CPL_T0_NS / `CLK_PERIOD_NS,
  parameter int CPL_CYC1 = `CPL_T1_NS / `CLK_PERIOD_NS,
  parameter int CPL_CYC2 = `CPL_T2_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Configuration access
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  input  wire logic        cfg_primary_i,
  input  wire logic        forward_mode_i,
  output logic             cfg_ack_o,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_crs_o,
  output logic             cfg_tretry_o,
  // Flow control
  input  wire logic        credit_freed_i,
  output logic             fc_update_o,
  // PCI retry tracking
  input  wire logic        pci_txn_new_i,
  input  wire logic        pci_retry_i,
  // Discard timer setup
  input  wire logic        bc_discard_dis_i,
  input  wire logic        bc_pri_discard_i,
  input  wire logic        bc_sec_discard_i,
  output logic             discard_en_o,
  output logic [15:0]      discard_limit_o,
  // Configuration request retry timer
  input  wire logic        crs_start_i,
  input  wire logic        crs_stop_i,
  output logic             crs_timeout_o,
  // Completion timer
  input  wire logic        cpl_start_i,
  input  wire logic        cpl_stop_i,
  output logic             cpl_timeout_o,
  // Transaction steering
  output logic [2:0]       tc_o,
  output logic             dt_in_order_o,
  // Power saving
  input  wire logic        link_l1_i,
  output logic             clk_gate_o
);
  import chip_ctl_pkg::*;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  retry_if    rif ();

  ////////////////////////////////////////////////////////////////////////////
  // Timer limits (cycles less one, since counting starts at zero)

  function automatic tcount_t crs_limit(input sel_t sel);
    unique case (sel)
      2'b00: crs_limit = tcount_t'(CRS_CYC0 - 1);
      2'b01: crs_limit = tcount_t'(CRS_CYC1 - 1);
      2'b10: crs_limit = tcount_t'(CRS_CYC2 - 1);
      2'b11: crs_limit = tcount_t'(CRS_CYC3 - 1);
    endcase
  endfunction

  function automatic tcount_t cpl_limit(input sel_t sel);
    unique case (sel)
      2'b00: cpl_limit = tcount_t'(CPL_CYC0 - 1);
      2'b01: cpl_limit = tcount_t'(CPL_CYC1 - 1);
      2'b10: cpl_limit = tcount_t'(CPL_CYC2 - 1);
      2'b11: cpl_limit = '1;
    endcase
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      lane_mask[i*8 +: 8] = {8{be[i]}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Retry counter

  pci_retry_counter u_retry (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .rif       (rif.cnt)
  );

  assign rif.limit_sel = st_r.ctl[`RETRY_SEL_HI:`RETRY_SEL_LO];
  assign rif.txn_new   = pci_txn_new_i;
  assign rif.retry     = pci_retry_i;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic        hit;
    logic        locked;
    logic [31:0] wmask;
    logic [31:0] ctl;
    sel_t        cpl_sel;
    hit     = 1'b0;
    locked  = 1'b0;
    wmask   = '0;
    ctl     = st_r.ctl;
    cpl_sel = st_r.ctl[`CPL_SEL_HI:`CPL_SEL_LO];
    st_nxt  = st_r;

    // Configuration access; the primary side is held off when locked
    hit    = (cfg_wr_i || cfg_rd_i) && cfg_addr_i == `CTL_OFFSET;
    locked = hit && cfg_primary_i && st_r.ctl[`LOCKOUT_BIT];
    st_nxt.cfg_ack    = hit && !locked;
    st_nxt.cfg_crs    = locked && forward_mode_i;
    st_nxt.cfg_tretry = locked && !forward_mode_i;
    st_nxt.cfg_rdata  = (hit && !locked && cfg_rd_i) ? st_r.ctl : '0;
    if (hit && !locked && cfg_wr_i) begin
      wmask = lane_mask(cfg_be_i) & `CTL_RW_MASK;
      ctl   = (ctl & ~wmask) | (cfg_wdata_i & wmask);
      if (cfg_be_i[2] && cfg_wdata_i[`RETRY_STS_BIT]) begin
        ctl[`RETRY_STS_BIT] = 1'b0;
      end
    end
    // Expiry in the same cycle as a clear still leaves the flag set
    if (rif.expired) begin
      ctl[`RETRY_STS_BIT] = 1'b1;
    end
    st_nxt.ctl = ctl;

    // Credit update pacing
    st_nxt.fc_update = 1'b0;
    if (credit_freed_i) begin
      if (st_r.ctl[`FC_BIT]) begin
        st_nxt.fc_update = 1'b1;
        st_nxt.fc_half   = 1'b0;
      end else begin
        st_nxt.fc_update = st_r.fc_half;
        st_nxt.fc_half   = !st_r.fc_half;
      end
    end

    // Configuration request retry timer
    st_nxt.crs_timeout = 1'b0;
    if (crs_start_i) begin
      st_nxt.crs_run = 1'b1;
      st_nxt.crs_cnt = '0;
    end else if (crs_stop_i) begin
      st_nxt.crs_run = 1'b0;
    end else if (st_r.crs_run) begin
      if (st_r.crs_cnt >=
          crs_limit(st_r.ctl[`CRS_SEL_HI:`CRS_SEL_LO])) begin
        st_nxt.crs_timeout = 1'b1;
        st_nxt.crs_run     = 1'b0;
      end else begin
        st_nxt.crs_cnt = st_r.crs_cnt + tcount_t'(1);
      end
    end

    // Completion timer; selection 11 keeps it from ever expiring
    st_nxt.cpl_timeout = 1'b0;
    if (cpl_start_i) begin
      st_nxt.cpl_run = 1'b1;
      st_nxt.cpl_cnt = '0;
    end else if (cpl_stop_i) begin
      st_nxt.cpl_run = 1'b0;
    end else if (st_r.cpl_run && cpl_sel != 2'b11) begin
      if (st_r.cpl_cnt >= cpl_limit(cpl_sel)) begin
        st_nxt.cpl_timeout = 1'b1;
        st_nxt.cpl_run     = 1'b0;
      end else begin
        st_nxt.cpl_cnt = st_r.cpl_cnt + tcount_t'(1);
      end
    end

    // Discard timer setup
    st_nxt.disc_en = !st_r.ctl[`DISC_DIS_BIT] && !bc_discard_dis_i;
    if (st_r.ctl[`DISC_SHORT_BIT]) begin
      st_nxt.disc_limit = `DISC_SHORT_CLK;
    end else if (forward_mode_i ? bc_pri_discard_i
                                : bc_sec_discard_i) begin
      st_nxt.disc_limit = `DISC_BC_SHORT;
    end else begin
      st_nxt.disc_limit = `DISC_BC_LONG;
    end

    // Steering and power
    st_nxt.tc = st_r.ctl[`ISO_EN_BIT] ? st_r.ctl[`TC_HI:`TC_LO]
                                      : `TC_ZERO;
    st_nxt.dt_in_order = st_r.ctl[`DT_ORDER_BIT];
    st_nxt.clk_gate    = st_r.ctl[`PWR_SAVE_BIT] && link_l1_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r            <= '0;
      st_r.ctl        <= `CTL_RESET;
      st_r.disc_en    <= 1'b1;
      st_r.disc_limit <= `DISC_BC_LONG;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_ack_o       = st_r.cfg_ack;
  assign cfg_rdata_o     = st_r.cfg_rdata;
  assign cfg_crs_o       = st_r.cfg_crs;
  assign cfg_tretry_o    = st_r.cfg_tretry;
  assign fc_update_o     = st_r.fc_update;
  assign discard_en_o    = st_r.disc_en;
  assign discard_limit_o = st_r.disc_limit;
  assign crs_timeout_o   = st_r.crs_timeout;
  assign cpl_timeout_o   = st_r.cpl_timeout;
  assign tc_o            = st_r.tc;
  assign dt_in_order_o   = st_r.dt_in_order;
  assign clk_gate_o      = st_r.clk_gate;
endmodule
`default_nettype wire

// [tb/chip_ctl_checker.sv]
/* Port checks for chip_ctl_upper, register answers and pulses.
   Assumes one clock domain and the bind at the foot of this file. */
`default_nettype none
module chip_ctl_checker (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       cfg_wr_i,
  input wire logic       cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic       cfg_primary_i,
  input wire logic       forward_mode_i,
  input wire logic       cfg_ack_o,
  input wire logic       cfg_crs_o,
  input wire logic       cfg_tretry_o,
  input wire logic       credit_freed_i,
  input wire logic       fc_update_o,
  input wire logic       bc_discard_dis_i,
  input wire logic       discard_en_o,
  input wire logic       crs_start_i,
  input wire logic       crs_timeout_o,
  input wire logic       cpl_start_i,
  input wire logic       cpl_timeout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic hit;
  assign hit = (cfg_wr_i || cfg_rd_i) && cfg_addr_i == 8'h40;
  //////////////////////////////////////////////////////////////////////
  property p_ack;
    hit |=> cfg_ack_o || cfg_crs_o || cfg_tretry_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("access not answered");
  property p_miss;
    (cfg_wr_i || cfg_rd_i) && !hit |=>
      !(cfg_ack_o || cfg_crs_o || cfg_tretry_o);
  endproperty
  a_miss: assert property (p_miss)
    else $error("unmapped access answered");
  property p_crs;
    cfg_crs_o |-> $past(hit) && $past(cfg_primary_i) && $past(forward_mode_i);
  endproperty
  a_crs: assert property (p_crs)
    else $error("retry status without forward primary access");
  property p_tretry;
    cfg_tretry_o |-> $past(hit) && $past(cfg_primary_i)
      && !$past(forward_mode_i);
  endproperty
  a_tretry: assert property (p_tretry)
    else $error("target retry without reverse primary access");
  property p_fc;
    fc_update_o |-> $past(credit_freed_i);
  endproperty
  a_fc: assert property (p_fc)
    else $error("credit update without freed credit");
  property p_disc;
    bc_discard_dis_i |=> !discard_en_o;
  endproperty
  a_disc: assert property (p_disc)
    else $error("discard timer left enabled");
  property p_crs_wait;
    crs_start_i |=> !crs_timeout_o [*2];
  endproperty
  a_crs_wait: assert property (p_crs_wait)
    else $error("config retry timer expired early");
  property p_cpl_wait;
    cpl_start_i |=> !cpl_timeout_o [*2];
  endproperty
  a_cpl_wait: assert property (p_cpl_wait)
    else $error("completion timer expired early");
  c_ack: cover property (hit ##1 cfg_ack_o);
  c_crs: cover property (cfg_crs_o);
  c_fc: cover property (fc_update_o);
  c_cpl: cover property (cpl_timeout_o);
endmodule
bind chip_ctl_upper chip_ctl_checker chk_u (.*);
`default_nettype wire

// [tb/pci_agent_model.sv]
/* Far-side agents: credit release from the link, retries on PCI.
   Assumes the bench calls its tasks from one thread. */
`default_nettype none
module pci_agent_model (
  input  wire logic clk_i,
  input  wire logic fc_update_i,
  output logic      credit_o,
  output logic      txn_new_o,
  output logic      retry_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int updates = 0;
  initial {credit_o, txn_new_o, retry_o} = 3'h0;
  always @(posedge clk_i) if (fc_update_i) updates++;
  // Gap adds idle edges after each one-cycle credit; gap 0 gives a credit every other edge
  task automatic credits(int n, int gap);
    repeat (n) begin
      @(posedge clk_i) credit_o <= 1'b1;
      @(posedge clk_i) credit_o <= 1'b0;
      repeat (gap) @(posedge clk_i);
    end
  endtask
  task automatic txn;
    @(posedge clk_i) txn_new_o <= 1'b1;
    @(posedge clk_i) txn_new_o <= 1'b0;
  endtask
  // Retry held for n edges, one retry counted per edge
  task automatic retries(int n);
    @(posedge clk_i) retry_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    retry_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
/* Self-checking bench for chip_ctl_upper with shortened timers.
   Assumes the checker binds itself and the agent model is compiled. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] d;
    logic [4:0]  in;
    logic [31:0] e;
    logic [2:0]  lv;
    logic [15:0] lim;
  } row_t;
  // in = {discard off, primary short, secondary short, forward, in L1}
  // lv = {en, gate, order}; last row leaves forward mode on
  row_t rows[7] = '{
    '{32'h0000_0000, 5'h06, 32'h0000_0000, 3'h4, 16'h8000},
    '{32'hffff_ffff, 5'h03, 32'hfffe_8000, 3'h3, 16'h0040},
    '{32'h0000_0000, 5'h0a, 32'h0000_0000, 3'h4, 16'h0400},
    '{32'h0000_0000, 5'h04, 32'h0000_0000, 3'h4, 16'h0400},
    '{32'h0000_0000, 5'h08, 32'h0000_0000, 3'h4, 16'h8000},
    '{32'h5c80_0000, 5'h03, 32'h5c80_0000, 3'h7, 16'h8000},
    '{32'h0920_0000, 5'h12, 32'h0920_0000, 3'h0, 16'h8000}};
  int crs_n[4] = '{8, 12, 16, 20};
  int cpl_n[4] = '{10, 14, 18, -1};
  logic clk_i, reset_n_i, cfg_wr_i, cfg_rd_i, cfg_primary_i;
  logic forward_mode_i, cfg_ack_o, cfg_crs_o, cfg_tretry_o;
  logic credit_freed_i, fc_update_o, pci_txn_new_i, pci_retry_i;
  logic bc_discard_dis_i, bc_pri_discard_i, bc_sec_discard_i;
  logic discard_en_o, crs_start_i, crs_stop_i, crs_timeout_o;
  logic cpl_start_i, cpl_stop_i, cpl_timeout_o;
  logic dt_in_order_o, link_l1_i, clk_gate_o;
  logic [7:0]  cfg_addr_i;
  logic [3:0]  cfg_be_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, rd;
  logic [15:0] discard_limit_o;
  logic [2:0]  tc_o, ans;
  int          errors = 0, num_checks = 0, u0, a, b;
  chip_ctl_upper #(.CRS_CYC0(8), .CRS_CYC1(12), .CRS_CYC2(16),
    .CRS_CYC3(20), .CPL_CYC0(10), .CPL_CYC1(14), .CPL_CYC2(18)) uut (.*);
  pci_agent_model agent (.clk_i, .fc_update_i(fc_update_o),
    .credit_o(credit_freed_i), .txn_new_o(pci_txn_new_i),
    .retry_o(pci_retry_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Answer stands from the taking edge on, sampled 1 ns after it
  task automatic acc(logic w, logic [7:0] ad, logic [3:0] be,
                     logic [31:0] d);
    @(posedge clk_i);
    cfg_wr_i <= w;
    cfg_rd_i <= !w;
    cfg_addr_i <= ad;
    cfg_be_i <= be;
    cfg_wdata_i <= d;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    cfg_rd_i <= 1'b0;
    #1 ans = {cfg_ack_o, cfg_crs_o, cfg_tretry_o};
    rd = cfg_rdata_o;
  endtask
  task automatic wr(logic [31:0] d, logic [3:0] be = 4'hf);
    acc(1'b1, 8'h40, be, d);
  endtask
  task automatic rdc(logic [31:0] e);
    acc(1'b0, 8'h40, 4'hf, 32'h0);
    chk("ans", 3'h4, ans);
    chk("rdata", e, rd);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // One-cycle start or stop pulse to both timers
  task automatic tmr(logic s, logic h);
    @(posedge clk_i);
    {crs_start_i, cpl_start_i, crs_stop_i, cpl_stop_i} <= {s, s, h, h};
    @(posedge clk_i);
    {crs_start_i, cpl_start_i, crs_stop_i, cpl_stop_i} <= 4'h0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {cfg_wr_i, cfg_rd_i, cfg_primary_i, bc_discard_dis_i} = 4'h0;
    {bc_pri_discard_i, bc_sec_discard_i, crs_stop_i, cpl_stop_i} = 4'h0;
    {crs_start_i, cpl_start_i, link_l1_i, reset_n_i} = 4'h0;
    {cfg_addr_i, cfg_be_i, cfg_wdata_i} = 44'h0;
    forward_mode_i = 1'b1;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    settle;
    chk("disc_en", 32'h1, discard_en_o);
    chk("disc_lim", 32'h8000, discard_limit_o);
    rdc(32'h0920_0000);
    acc(1'b1, 8'h44, 4'hf, 32'h0);
    chk("unmapped", 3'h0, ans);
    foreach (rows[i]) begin
      @(posedge clk_i);
      {bc_discard_dis_i, bc_pri_discard_i, bc_sec_discard_i,
       forward_mode_i, link_l1_i} <= rows[i].in;
      wr(rows[i].d);
      settle;
      chk("lv", rows[i].lv, {discard_en_o, clk_gate_o, dt_in_order_o});
      chk("lim", rows[i].lim, discard_limit_o);
      chk("tc", rows[i].e[26] ? rows[i].e[29:27] : 3'h0, tc_o);
      rdc(rows[i].e);
    end
    u0 = agent.updates;
    agent.credits(4, 1);
    settle;
    chk("fc_half", 2, agent.updates - u0);
    wr(32'h0920_8000);
    agent.credits(3, 0);
    settle;
    chk("fc_each", 5, agent.updates - u0);
    wr(32'h0002_0000);
    agent.txn();
    agent.retries(200);
    agent.txn();
    agent.retries(255);
    settle;
    rdc(32'h0002_0000);
    agent.retries(1);
    settle;
    rdc(32'h0003_0000);
    wr(32'h0003_0000, 4'h4);
    rdc(32'h0002_0000);
    for (int k = 0; k < 4; k++) begin
      wr({6'h0, k[1:0], 1'b0, k[1:0], 21'h0});
      tmr(1'b1, 1'b0);
      a = 0;
      b = 0;
      for (int c = 1; c < 40; c++) begin
        #1;
        if (crs_timeout_o === 1'b1) a = c;
        if (cpl_timeout_o === 1'b1) b = c;
        @(posedge clk_i);
      end
      chk("crs_time", crs_n[k] + 1, a);
      chk("cpl_time", cpl_n[k] + 1, b);
    end
    // A stop shortly after start must keep both timers quiet
    wr(32'h0);
    tmr(1'b1, 1'b0);
    tmr(1'b0, 1'b1);
    a = 0;
    repeat (30) begin
      @(posedge clk_i);
      #1;
      if ({crs_timeout_o, cpl_timeout_o} !== 2'b00) a++;
    end
    chk("stopped", 32'h0, a);
    wr(32'h8920_0000);
    @(posedge clk_i) cfg_primary_i <= 1'b1;
    for (int f = 1; f >= 0; f--) begin
      @(posedge clk_i) forward_mode_i <= f[0];
      acc(f[0], 8'h40, 4'hf, 32'h0);
      chk("locked", f ? 32'h2 : 32'h1, ans);
      chk("no_data", 32'h0, rd);
    end
    @(posedge clk_i) cfg_primary_i <= 1'b0;
    rdc(32'h8920_0000);
    // Reset in mid-run brings the register back to its reset value
    @(posedge clk_i) reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    settle;
    rdc(32'h0920_0000);
    results;
  end
endmodule
`default_nettype wire
